/* File: sol_pkg.sv */
// constants and types for the serial link out-of-band init block
package sol_pkg;
  localparam int CLK_PERIOD_PS = 8000;
  // gen1 unit interval is 2000/3 ps
  localparam int GEN1_UI_NUM_PS = 2000;
  localparam int GEN1_UI_DEN    = 3;
  localparam int BURST_UI       = 160;
  localparam int GAP_UI         = 480;
  localparam int DWORD_UI       = 40;
  localparam int ALIGN_TO_DWORDS = 2048;
  localparam int GAP_MIN_NS     = 175;
  localparam int GAP_MAX_NS     = 525;
  localparam int RELEASE_NS     = 525;

  function automatic int ui_cyc_ceil(input int ui);
    return (ui * GEN1_UI_NUM_PS + GEN1_UI_DEN * CLK_PERIOD_PS - 1) /
           (GEN1_UI_DEN * CLK_PERIOD_PS);
  endfunction

  localparam logic [6:0] BURST_CYC   = 7'(ui_cyc_ceil(BURST_UI));
  localparam logic [6:0] GAP_CYC     = 7'(ui_cyc_ceil(GAP_UI));
  localparam logic [6:0] GAP_MIN_CYC =
    7'((GAP_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [6:0] GAP_MAX_CYC = 7'(GAP_MAX_NS * 1000 / CLK_PERIOD_PS);
  localparam logic [6:0] RELEASE_CYC =
    7'((RELEASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // longest wait, so rounded down
  localparam logic [15:0] ALIGN_TO_CYC =
    16'((ALIGN_TO_DWORDS * DWORD_UI * GEN1_UI_NUM_PS) /
        (GEN1_UI_DEN * CLK_PERIOD_PS));

  localparam logic [2:0] INIT_BURSTS   = 3'h6;
  localparam logic [2:0] WAKE_BURSTS   = 3'h6;
  localparam logic [2:0] DETECT_BURSTS = 3'h4;
  localparam logic [1:0] NONALIGN_NEED = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_INIT_TX   = 4'h1,
    ST_WAIT_WAKE = 4'h3,
    ST_CALIB     = 4'h2,
    ST_WAKE_TX   = 4'h6,
    ST_ALIGN     = 4'h7,
    ST_SYNC      = 4'h5,
    ST_READY     = 4'h4,
    ST_ERROR     = 4'hc,
    ST_SLEEP     = 4'h8
  } sol_state_t;

  typedef enum logic [1:0] {
    GEN_IDLE  = 2'h0,
    GEN_BURST = 2'h1,
    GEN_GAP   = 2'h3,
    GEN_REL   = 2'h2
  } sol_gen_ph_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'h0,
    TX_BURST = 2'h1,
    TX_ALIGN = 2'h2,
    TX_SYNC  = 2'h3
  } sol_tx_mode_t;

  typedef enum logic [1:0] {
    SPD_GEN1 = 2'h0,
    SPD_GEN2 = 2'h1,
    SPD_GEN3 = 2'h2
  } sol_speed_t;
endpackage

/* File: sol_burst_gen.sv */
// out-of-band burst and idle sequencer for the transmit side
`timescale 1ns/100ps
module sol_burst_gen (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       start_in,
  input  wire logic [2:0] count_in,
  input  wire logic [6:0] gap_cyc_in,
  output logic            burst_out,
  output logic            busy_out,
  output logic            done_out
);
  import sol_pkg::*;

  sol_gen_ph_t ph_ff, nxt_ph;
  logic [6:0]  cnt_ff, nxt_cnt;
  logic [6:0]  gap_ff, nxt_gap;
  logic [2:0]  left_ff, nxt_left;
  logic        burst_ff, nxt_burst;
  logic        done_ff, nxt_done;

  always_comb begin
    nxt_ph    = ph_ff;
    nxt_cnt   = cnt_ff + 7'h1;
    nxt_gap   = gap_ff;
    nxt_left  = left_ff;
    nxt_burst = burst_ff;
    nxt_done  = 1'b0;
    case (ph_ff)
      GEN_IDLE: begin
        nxt_cnt = 7'h0;
        if (start_in && count_in != 3'h0) begin
          nxt_ph    = GEN_BURST;
          nxt_left  = count_in;
          nxt_gap   = gap_cyc_in;
          nxt_burst = 1'b1;
        end
      end
      GEN_BURST: begin
        if (cnt_ff == BURST_CYC - 7'h1) begin
          nxt_cnt   = 7'h0;
          nxt_left  = left_ff - 3'h1;
          nxt_burst = 1'b0;
          nxt_ph    = (left_ff == 3'h1) ? GEN_REL : GEN_GAP;
        end
      end
      GEN_GAP: begin
        if (cnt_ff == gap_ff - 7'h1) begin
          nxt_cnt   = 7'h0;
          nxt_burst = 1'b1;
          nxt_ph    = GEN_BURST;
        end
      end
      GEN_REL: begin
        if (cnt_ff == RELEASE_CYC - 7'h1) begin
          nxt_ph   = GEN_IDLE;
          nxt_done = 1'b1;
        end
      end
      default: begin
        nxt_ph    = GEN_IDLE;
        nxt_burst = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ph_ff    <= GEN_IDLE;
      cnt_ff   <= 7'h0;
      gap_ff   <= 7'h0;
      left_ff  <= 3'h0;
      burst_ff <= 1'b0;
      done_ff  <= 1'b0;
    end else begin
      ph_ff    <= nxt_ph;
      cnt_ff   <= nxt_cnt;
      gap_ff   <= nxt_gap;
      left_ff  <= nxt_left;
      burst_ff <= nxt_burst;
      done_ff  <= nxt_done;
    end
  end

  assign burst_out = burst_ff;
  assign busy_out  = (ph_ff != GEN_IDLE);
  assign done_out  = done_ff;

  // run lengths seen on the line, for checking only
  logic [6:0] hi_cnt_ff;
  logic [6:0] lo_cnt_ff;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      hi_cnt_ff <= 7'h0;
      lo_cnt_ff <= 7'h0;
    end else begin
      hi_cnt_ff <= burst_ff ? hi_cnt_ff + 7'h1 : 7'h0;
      lo_cnt_ff <= (burst_ff || lo_cnt_ff == 7'h7f) ?
                   (burst_ff ? 7'h0 : lo_cnt_ff) : lo_cnt_ff + 7'h1;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_burst_len;
    $fell(burst_ff) |-> hi_cnt_ff == BURST_CYC;
  endproperty
  a_burst_len: assert property (p_burst_len)
    else $error("burst length wrong");

  property p_gap_len;
    $rose(burst_ff) && $past(ph_ff) == GEN_GAP |-> lo_cnt_ff == gap_ff;
  endproperty
  a_gap_len: assert property (p_gap_len)
    else $error("inter-burst gap wrong");

  property p_release;
    done_ff |-> lo_cnt_ff >= RELEASE_CYC && !burst_ff;
  endproperty
  a_release: assert property (p_release)
    else $error("release idle too short");
endmodule // sol_burst_gen

/* File: sol_oob_init.sv */
// device-side out-of-band link init, speed step-down and sleep control
// Function
// - a burst is four gen1 align or d24.3 dwords, 160 ui long
// - reset-type burst 160 ui, idle gap 480 ui between bursts
// - wake signal brings the phy out of partial or slumber; here low power ends when the sleep request pin drops, not on wake
// - reset signal comes only from host; device then resets itself
// - four consecutive bursts with nominal 320 ns gaps mean reset
// - a gap under 175 ns or over 525 ns voids reset detection
// - line stays idle at least 525 ns after the final burst
// - device answers reset release with init; may send init anytime; here a request is dropped while the burst generator is busy
// - on host wake, optional calibrate, six-burst wake, align at top
// - no host align in 2048 dword times, drop to next lower speed
// - lowest speed tried without answer puts device in error state
// - locked and ready device sends sync primitives
// - sleep request pin high puts device into low power
// - three consecutive non-align primitives mean link established
// - init uses the same burst and gap timing as reset
`timescale 1ns/100ps
module sol_oob_init #(
  parameter logic [15:0] ALIGN_TIMEOUT_CYC = sol_pkg::ALIGN_TO_CYC
) (
  input  wire logic               sys_clk_in,
  input  wire logic               rst_n_in,
  input  wire logic               rx_burst_in,
  input  wire logic               rx_prim_valid_in,
  input  wire logic               rx_prim_align_in,
  input  wire logic               rx_lock_in,
  input  wire logic               tx_calib_done_in,
  input  wire logic               dev_init_req_in,
  input  wire logic               sleep_request_pin_in,
  output logic                    hw_reset_out,
  output logic                    tx_burst_out,
  output sol_pkg::sol_tx_mode_t   tx_mode_out,
  output sol_pkg::sol_speed_t     tx_speed_out,
  output logic                    link_up_out,
  output logic                    link_error_out,
  output logic                    low_power_out
);
  import sol_pkg::*;

  // receive pattern detector state
  logic       rx_prev_ff, nxt_rx_prev;
  logic [6:0] gap_cnt_ff, nxt_gap_cnt;
  logic [2:0] nb_ff, nxt_nb;
  logic       kind_ff, nxt_kind;
  logic       rst_seen_ff, nxt_rst_seen;
  logic       wake_seen_ff, nxt_wake_seen;
  logic       rise, rst_gap, rst_rel, wake_rel;

  always_comb begin
    nxt_rx_prev   = rx_burst_in;
    nxt_gap_cnt   = rx_burst_in ? 7'h0 :
                    (gap_cnt_ff == 7'h7f ? gap_cnt_ff : gap_cnt_ff + 7'h1);
    nxt_nb        = nb_ff;
    nxt_kind      = kind_ff;
    nxt_rst_seen  = rst_seen_ff;
    nxt_wake_seen = wake_seen_ff;
    rise          = rx_burst_in && !rx_prev_ff;
    rst_gap       = gap_cnt_ff >= GAP_MIN_CYC && gap_cnt_ff <= GAP_MAX_CYC;
    rst_rel       = 1'b0;
    wake_rel      = 1'b0;
    if (rise) begin
      if (nb_ff == 3'h0 || gap_cnt_ff > GAP_MAX_CYC) begin
        nxt_nb = 3'h1;
      end else if (nb_ff == 3'h1 || kind_ff == rst_gap) begin
        nxt_nb   = (nb_ff == DETECT_BURSTS) ? nb_ff : nb_ff + 3'h1;
        nxt_kind = rst_gap;
      end else begin
        // pattern changed; this pair starts a fresh count
        nxt_nb   = 3'h2;
        nxt_kind = rst_gap;
      end
      if (!rst_gap) begin
        nxt_rst_seen = 1'b0;
      end
      if (nxt_nb == DETECT_BURSTS && nxt_kind) begin
        nxt_rst_seen = 1'b1;
      end
      if (nxt_nb == DETECT_BURSTS && !nxt_kind) begin
        nxt_wake_seen = 1'b1;
      end
    end else if (!rx_burst_in && gap_cnt_ff == RELEASE_CYC - 7'h1) begin
      // line quiet long enough: pattern released
      rst_rel       = rst_seen_ff;
      wake_rel      = wake_seen_ff;
      nxt_rst_seen  = 1'b0;
      nxt_wake_seen = 1'b0;
      nxt_nb        = 3'h0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rx_prev_ff   <= 1'b0;
      gap_cnt_ff   <= 7'h0;
      nb_ff        <= 3'h0;
      kind_ff      <= 1'b0;
      rst_seen_ff  <= 1'b0;
      wake_seen_ff <= 1'b0;
    end else begin
      rx_prev_ff   <= nxt_rx_prev;
      gap_cnt_ff   <= nxt_gap_cnt;
      nb_ff        <= nxt_nb;
      kind_ff      <= nxt_kind;
      rst_seen_ff  <= nxt_rst_seen;
      wake_seen_ff <= nxt_wake_seen;
    end
  end

  // main sequencer state
  sol_state_t   state_ff, nxt_state;
  sol_speed_t   speed_ff, nxt_speed;
  sol_tx_mode_t mode_ff, nxt_mode;
  logic [15:0]  timer_ff, nxt_timer;
  logic         align_ok_ff, nxt_align_ok;
  logic [1:0]   nonal_ff, nxt_nonal;
  logic         link_up_ff, link_err_ff, low_pwr_ff, hw_rst_ff;
  logic         gen_start, gen_busy, gen_done, gen_burst, quiet, gen_rst_n;
  logic [2:0]   gen_count;
  logic [6:0]   gen_gap;
  logic         rx_align, rx_nonalign;

  assign rx_align    = rx_prim_valid_in && rx_prim_align_in;
  assign rx_nonalign = rx_prim_valid_in && !rx_prim_align_in;
  assign quiet = !nxt_rst_seen && !sleep_request_pin_in && !dev_init_req_in;

  always_comb begin
    nxt_state    = state_ff;
    nxt_speed    = speed_ff;
    nxt_timer    = timer_ff + 16'h1;
    nxt_align_ok = align_ok_ff;
    nxt_nonal    = nonal_ff;
    gen_start    = 1'b0;
    gen_count    = INIT_BURSTS;
    gen_gap      = GAP_CYC;
    case (state_ff)
      ST_IDLE: begin
        if (rst_rel && !gen_busy) begin
          gen_start = 1'b1;
          nxt_state = ST_INIT_TX;
        end
      end
      ST_INIT_TX: if (gen_done) nxt_state = ST_WAIT_WAKE;
      ST_WAIT_WAKE: if (wake_rel) nxt_state = ST_CALIB;
      ST_CALIB: begin
        if (tx_calib_done_in && !gen_busy) begin
          gen_start = 1'b1;
          gen_count = WAKE_BURSTS;
          gen_gap   = BURST_CYC;
          nxt_state = ST_WAKE_TX;
        end
      end
      ST_WAKE_TX: begin
        if (gen_done) begin
          nxt_state    = ST_ALIGN;
          nxt_speed    = SPD_GEN3;
          nxt_timer    = 16'h0;
          nxt_align_ok = 1'b0;
        end
      end
      ST_ALIGN: begin
        if (rx_align) nxt_align_ok = 1'b1;
        if ((align_ok_ff || rx_align) && rx_lock_in) begin
          nxt_state = ST_SYNC;
          nxt_nonal = 2'h0;
        end else if (!align_ok_ff && !rx_align &&
                     timer_ff == ALIGN_TIMEOUT_CYC - 16'h1) begin
          nxt_timer = 16'h0;
          if (speed_ff == SPD_GEN1) begin
            nxt_state = ST_ERROR;
          end else begin
            nxt_speed = sol_speed_t'(speed_ff - 2'h1);
          end
        end
      end
      ST_SYNC: begin
        if (rx_align) begin
          nxt_nonal = 2'h0;
        end else if (rx_nonalign) begin
          nxt_nonal = nonal_ff + 2'h1;
          if (nonal_ff == NONALIGN_NEED - 2'h1) nxt_state = ST_READY;
        end
      end
      ST_READY: if (wake_rel) nxt_state = ST_CALIB;
      ST_ERROR: ;
      ST_SLEEP: if (!sleep_request_pin_in) nxt_state = ST_WAIT_WAKE;
      default: nxt_state = ST_IDLE;
    endcase
    if (dev_init_req_in && !gen_busy && state_ff != ST_INIT_TX) begin
      gen_start = 1'b1;
      gen_count = INIT_BURSTS;
      gen_gap   = GAP_CYC;
      nxt_state = ST_INIT_TX;
    end
    if (sleep_request_pin_in) begin
      gen_start = 1'b0;
      nxt_state = ST_SLEEP;
    end
    if (nxt_rst_seen) begin
      gen_start = 1'b0;
      nxt_state = ST_IDLE;
    end
    case (nxt_state)
      ST_INIT_TX, ST_WAKE_TX: nxt_mode = TX_BURST;
      ST_ALIGN:               nxt_mode = TX_ALIGN;
      ST_SYNC, ST_READY:      nxt_mode = TX_SYNC;
      default:                nxt_mode = TX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_ff    <= ST_IDLE;
      speed_ff    <= SPD_GEN3;
      mode_ff     <= TX_IDLE;
      timer_ff    <= 16'h0;
      align_ok_ff <= 1'b0;
      nonal_ff    <= 2'h0;
      link_up_ff  <= 1'b0;
      link_err_ff <= 1'b0;
      low_pwr_ff  <= 1'b0;
      hw_rst_ff   <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      speed_ff    <= nxt_speed;
      mode_ff     <= nxt_mode;
      timer_ff    <= nxt_timer;
      align_ok_ff <= nxt_align_ok;
      nonal_ff    <= nxt_nonal;
      link_up_ff  <= (nxt_state == ST_READY);
      link_err_ff <= (nxt_state == ST_ERROR);
      low_pwr_ff  <= (nxt_state == ST_SLEEP);
      hw_rst_ff   <= nxt_rst_seen;
    end
  end

  // host reset also stops a half-sent init
  // otherwise the release would find the generator busy and no init follows
  assign gen_rst_n = rst_n_in && !nxt_rst_seen;

  sol_burst_gen u_gen (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (gen_rst_n),
    .start_in   (gen_start),
    .count_in   (gen_count),
    .gap_cyc_in (gen_gap),
    .burst_out  (gen_burst),
    .busy_out   (gen_busy),
    .done_out   (gen_done)
  );

  assign hw_reset_out   = hw_rst_ff;
  assign tx_burst_out   = gen_burst;
  assign tx_mode_out    = mode_ff;
  assign tx_speed_out   = speed_ff;
  assign link_up_out    = link_up_ff;
  assign link_error_out = link_err_ff;
  assign low_power_out  = low_pwr_ff;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_timeout;
    state_ff == ST_ALIGN && !align_ok_ff && !rx_align && quiet &&
    timer_ff == ALIGN_TIMEOUT_CYC - 16'h1;
  endsequence

  property p_detect;
    rise && nb_ff == 3'h3 && kind_ff && rst_gap |=> hw_reset_out;
  endproperty
  a_detect: assert property (p_detect)
    else $error("reset pattern missed");

  property p_reject;
    rise && !rst_gap |=> !hw_reset_out;
  endproperty
  a_reject: assert property (p_reject)
    else $error("bad gap did not void reset");

  property p_hw_reset;
    hw_reset_out |-> state_ff == ST_IDLE && tx_mode_out == TX_IDLE &&
      !tx_burst_out;
  endproperty
  a_hw_reset: assert property (p_hw_reset)
    else $error("device active during reset");

  property p_init_reply;
    state_ff == ST_IDLE && rst_rel && quiet && !gen_busy
      |=> state_ff == ST_INIT_TX && tx_burst_out ##1 tx_mode_out == TX_BURST;
  endproperty
  a_init_reply: assert property (p_init_reply)
    else $error("no init after reset release");

  property p_align_top;
    $rose(state_ff == ST_ALIGN) |->
      tx_speed_out == SPD_GEN3 && tx_mode_out == TX_ALIGN;
  endproperty
  a_align_top: assert property (p_align_top)
    else $error("align not started at top speed");

  property p_step_down;
    s_timeout ##0 tx_speed_out != SPD_GEN1 |=>
      tx_speed_out == sol_speed_t'($past(tx_speed_out) - 2'h1) &&
      state_ff == ST_ALIGN;
  endproperty
  a_step_down: assert property (p_step_down)
    else $error("speed not stepped down");

  property p_error;
    s_timeout ##0 tx_speed_out == SPD_GEN1 |=>
      state_ff == ST_ERROR && link_error_out;
  endproperty
  a_error: assert property (p_error)
    else $error("no error after lowest speed");

  property p_sync;
    state_ff == ST_SYNC |-> tx_mode_out == TX_SYNC && !link_up_out;
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync not sent while locking");

  property p_sleep;
    sleep_request_pin_in && !nxt_rst_seen |=>
      low_power_out && tx_mode_out == TX_IDLE;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep request ignored");

  property p_link_up;
    state_ff == ST_SYNC && rx_nonalign && nonal_ff == 2'h2 && quiet
      |=> link_up_out ##1 link_up_out || !quiet;
  endproperty
  a_link_up: assert property (p_link_up)
    else $error("link not up after three non-align");
endmodule // sol_oob_init

/* File: sol_host_model.sv */
// host-side model: out-of-band bursts and received primitives
`timescale 1ns/100ps
module sol_host_model (
  input  wire logic sys_clk_in,
  output logic      rx_burst_out,
  output logic      prim_valid_out,
  output logic      prim_align_out
);
  initial begin
    rx_burst_out   = 1'b0;
    prim_valid_out = 1'b0;
    prim_align_out = 1'b0;
  end

  task automatic oob(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      rx_burst_out = 1'b1;
      repeat (int'(sol_pkg::BURST_CYC)) @(negedge sys_clk_in);
      rx_burst_out = 1'b0;
      if (i < n - 1) repeat (gap) @(negedge sys_clk_in);
    end
  endtask

  task automatic quiet();
    repeat (int'(sol_pkg::RELEASE_CYC)) @(negedge sys_clk_in);
  endtask

  task automatic prim(input logic align);
    prim_valid_out = 1'b1;
    prim_align_out = align;
    @(negedge sys_clk_in);
    prim_valid_out = 1'b0;
    prim_align_out = ~align;
    @(negedge sys_clk_in);
  endtask
endmodule // sol_host_model

/* File: test_sol_oob_init.sv */
// self-checking bench for the out-of-band link init block
`timescale 1ns/100ps
module test_sol_oob_init;
  import sol_pkg::*;
  logic sys_clk, rst_n, rx_burst, p_valid, p_align, lock, calib;
  logic init_req, sleep, hw_reset, tx_burst, link_up, link_error, low_pwr;
  sol_tx_mode_t tx_mode;
  sol_speed_t   tx_speed;
  int failures   = 0;
  int n_compared = 0;

  sol_host_model host (
    .sys_clk_in     (sys_clk),
    .rx_burst_out   (rx_burst),
    .prim_valid_out (p_valid),
    .prim_align_out (p_align)
  );

  // short align timeout keeps the run brief
  sol_oob_init #(.ALIGN_TIMEOUT_CYC(16'h0032)) dut (
    .sys_clk_in           (sys_clk),
    .rst_n_in             (rst_n),
    .rx_burst_in          (rx_burst),
    .rx_prim_valid_in     (p_valid),
    .rx_prim_align_in     (p_align),
    .rx_lock_in           (lock),
    .tx_calib_done_in     (calib),
    .dev_init_req_in      (init_req),
    .sleep_request_pin_in (sleep),
    .hw_reset_out         (hw_reset),
    .tx_burst_out         (tx_burst),
    .tx_mode_out          (tx_mode),
    .tx_speed_out         (tx_speed),
    .link_up_out          (link_up),
    .link_error_out       (link_error),
    .low_power_out        (low_pwr)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // a wait that ran out ends the run
  task automatic bound(input int k, input int lim);
    if (k >= lim) begin
      failures++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      report_and_stop();
    end
  endtask

  task automatic wait_mode(input sol_tx_mode_t m, input int lim);
    int k;
    for (k = 0; k < lim && tx_mode !== m; k++) @(negedge sys_clk);
    bound(k, lim);
  endtask

  task automatic measure_tx(input int n, input int gap);
    int k, hi;
    for (int i = 0; i < n; i++) begin
      for (k = 0; k < 100 && tx_burst !== 1'b1; k++) @(negedge sys_clk);
      bound(k, 100);
      if (i > 0) chk(16'(k), 16'(gap));
      for (hi = 0; hi < 100 && tx_burst === 1'b1; hi++) @(negedge sys_clk);
      chk(16'(hi), 16'h000e);
    end
  endtask

  task automatic bad_gaps();
    host.oob(4, 21);
    chk(hw_reset, 1'b0);
    host.quiet();
    host.oob(4, 66);
    chk(hw_reset, 1'b0);
    host.quiet();
  endtask

  task automatic reset_init();
    int hi = 0;
    // host resets over a half-sent init
    init_req = 1'b1;
    @(negedge sys_clk);
    init_req = 1'b0;
    host.oob(4, 65);
    @(negedge sys_clk);
    chk(hw_reset, 1'b1);
    for (int i = 0; i < 40; i++) begin
      @(negedge sys_clk);
      if (tx_burst === 1'b1) hi++;
    end
    chk(16'(hi), 16'h0000);
    host.oob(2, 40);
    repeat (60) @(negedge sys_clk);
    chk(hw_reset, 1'b1);
    wait_mode(TX_BURST, 12);
    chk(hw_reset, 1'b0);
    measure_tx(6, 40);
    wait_mode(TX_IDLE, 80);
  endtask

  task automatic wake_timeout();
    int k;
    host.oob(6, 14);
    host.quiet();
    measure_tx(6, 14);
    wait_mode(TX_ALIGN, 100);
    chk(tx_speed, SPD_GEN3);
    for (int s = 2; s > 0; s--) begin
      for (k = 0; k < 100 && tx_speed === sol_speed_t'(s); k++) begin
        @(negedge sys_clk);
      end
      chk(16'(k >= 49 && k <= 51), 16'h0001);
      chk(tx_speed, 16'(s - 1));
    end
    for (k = 0; k < 100 && link_error !== 1'b1; k++) @(negedge sys_clk);
    chk(16'(k >= 49 && k <= 51), 16'h0001);
  endtask

  task automatic mid_reset();
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(link_error, 1'b0);
    chk(tx_speed, SPD_GEN3);
    rst_n = 1'b1;
    @(negedge sys_clk);
    chk(tx_mode, TX_IDLE);
    chk(hw_reset, 1'b0);
  endtask

  task automatic init_sync_link();
    init_req = 1'b1;
    @(negedge sys_clk);
    init_req = 1'b0;
    wait_mode(TX_BURST, 5);
    chk(tx_burst, 1'b1);
    wait_mode(TX_IDLE, 600);
    host.oob(6, 14);
    host.quiet();
    wait_mode(TX_ALIGN, 400);
    host.prim(1'b1);
    repeat (60) @(negedge sys_clk);
    // align seen, receiver not locked yet
    chk(tx_mode, TX_ALIGN);
    chk(tx_speed, SPD_GEN3);
    lock = 1'b1;
    wait_mode(TX_SYNC, 5);
    host.prim(1'b0);
    host.prim(1'b0);
    host.prim(1'b1);
    host.prim(1'b0);
    host.prim(1'b0);
    chk(link_up, 1'b0);
    host.prim(1'b0);
    @(negedge sys_clk);
    chk(link_up, 1'b1);
    // wake from ready, then lock again
    host.oob(6, 14);
    host.quiet();
    wait_mode(TX_BURST, 20);
    chk(link_up, 1'b0);
    wait_mode(TX_ALIGN, 400);
    host.prim(1'b1);
    repeat (3) host.prim(1'b0);
    chk(link_up, 1'b1);
  endtask

  task automatic sleep_wake();
    sleep = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(low_pwr, 1'b1);
    chk(link_up, 1'b0);
    sleep = 1'b0;
    calib = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(low_pwr, 1'b0);
    host.oob(6, 14);
    host.quiet();
    repeat (10) @(negedge sys_clk);
    // held back until calibration ends
    chk(tx_burst, 1'b0);
    calib = 1'b1;
    wait_mode(TX_BURST, 20);
  endtask

  initial begin
    rst_n    = 1'b0;
    lock     = 1'b0;
    calib    = 1'b1;
    init_req = 1'b0;
    sleep    = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(tx_speed, SPD_GEN3);
    chk(hw_reset, 1'b0);
    rst_n = 1'b1;
    @(negedge sys_clk);
    bad_gaps();
    reset_init();
    wake_timeout();
    mid_reset();
    init_sync_link();
    sleep_wake();
    report_and_stop();
  end
endmodule // test_sol_oob_init
